// >>> bench/cvc_host_model.sv
// Host register master: byte writes and two-byte burst reads
`timescale 1ns/10ps
`include "cvc_params.svh"
module cvc_host_model
    import cvc_pkg::*;
(
    input  wire logic       clk,
    output logic            wr_en,
    output logic            rd_en,
    output logic            rd_first,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata,
    input  wire logic       rd_valid
);
    // Idle bus from time zero
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        rd_first = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    // One byte per write, held up to the taking edge
    task automatic write_byte(input cvc_byte_t a, input cvc_byte_t d);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        @(posedge clk);
        #1;
    endtask : write_byte
    // Burst of two bytes; second byte uses the advanced pointer
    task automatic read_pair(input cvc_byte_t a, output cvc_byte_t lo, output cvc_byte_t hi,
                             output logic ok);
        rd_en = 1'b1;
        rd_first = 1'b1;
        addr = a;
        @(posedge clk);
        #1;
        lo = rdata;
        ok = rd_valid;
        rd_first = 1'b0;
        @(posedge clk);
        #1;
        hi = rdata;
        ok = ok & rd_valid;
        rd_en = 1'b0;
        @(posedge clk);
        #1;
    endtask : read_pair
    // Motion sensors to full mode before the channel is used
    task automatic bring_up();
        write_byte(`CVC_ADDR_ACCEL, 8'h07);
        write_byte(`CVC_ADDR_GYRO, 8'h07);
    endtask : bring_up
endmodule : cvc_host_model

// >>> bench/testbench.sv
// Self-checking bench for the charge channel controller
`timescale 1ns/10ps
`include "cvc_params.svh"
module testbench
    import cvc_pkg::*;
;
    logic        CLOCK, RESETN, CE, WR_EN, RD_EN, RD_FIRST, RD_VALID, PIN, PUSH, CVALID;
    logic [7:0]  ADDR, WDATA, RDATA, ACC, GYR;
    logic [1:0]  ZIN;
    logic        EA, EB, SW;
    cvc_sample_t IN_A, IN_B, FDATA, CDATA;
    int          mismatches, samples_checked;
    ////////////////////////////////////////////////////////////////////////
    // Clock and instances
    always #5 CLOCK = ~CLOCK;
    cvc_ctrl #(.SAMPLE_PERIOD(20)) cvc_ctrl_inst (.CLOCK(CLOCK), .RESETN(RESETN), .CE(CE),
        .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_FIRST(RD_FIRST), .ADDR(ADDR), .WDATA(WDATA),
        .RDATA(RDATA), .RD_VALID(RD_VALID), .ELECTRODE_IN_A(IN_A), .ELECTRODE_IN_B(IN_B),
        .ACCEL_MODE(ACC), .GYRO_MODE(GYR), .INPUT_IMPEDANCE_SEL(ZIN), .ELECTRODE_A_ENABLE(EA),
        .ELECTRODE_B_ENABLE(EB), .ELECTRODE_SWAP(SW), .SECOND_INTERRUPT_PIN(PIN),
        .FIFO_PUSH(PUSH), .FIFO_DATA(FDATA), .CORE_SAMPLE_VALID(CVALID), .CORE_SAMPLE(CDATA));
    cvc_host_model cvc_host_model_inst (.clk(CLOCK), .wr_en(WR_EN), .rd_en(RD_EN),
        .rd_first(RD_FIRST), .addr(ADDR), .wdata(WDATA), .rdata(RDATA), .rd_valid(RD_VALID));
    ////////////////////////////////////////////////////////////////////////
    // Compare and verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    // Saturated difference of the routed electrodes
    function automatic cvc_sample_t exp_sample(cvc_sample_t a, cvc_sample_t b, logic s,
                                               logic ea, logic eb);
        int d;
        d = (ea ? (s ? b : a) : 0) - (eb ? (s ? a : b) : 0);
        if (d > 32767) d = 32767;
        if (d < -32768) d = -32768;
        return cvc_sample_t'(d);
    endfunction : exp_sample
    // Cycles up to the next sample strobe, 60 meaning none
    task automatic wait_pulse(output int n);
        n = 0;
        do begin
            @(posedge CLOCK);
            #1;
            n++;
        end while (CVALID !== 1'b1 && n < 60);
    endtask : wait_pulse
    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        cvc_byte_t   lo, hi, cfg;
        cvc_byte_t   regs[4];
        logic        ok, s;
        int          n;
        cvc_sample_t e;
        regs = '{8'h0b, 8'h10, 8'h16, 8'h19};
        CLOCK = 1'b0;
        RESETN = 1'b0;
        CE = 1'b1;
        IN_A = 16'h0000;
        IN_B = 16'h0000;
        mismatches = 0;
        samples_checked = 0;
        void'($urandom(32'h7b05));
        repeat (16) @(posedge CLOCK);
        #1;
        RESETN = 1'b1;
        foreach (regs[k]) begin
            cvc_host_model_inst.read_pair(regs[k], lo, hi, ok);
            check({hi, lo}, 16'h0000);
            check(ok, 1'b1);
        end
        cvc_host_model_inst.bring_up();
        check({ACC, GYR}, 16'h0707);
        cvc_host_model_inst.write_byte(`CVC_ADDR_BATCH, 8'h04);
        for (int i = 0; i < 4; i++) begin
            s = i[0];
            cfg = (i == 0) ? 8'hcc : {4'hc, 1'($urandom), 1'($urandom), i[1:0]};
            IN_A = (i == 0) ? 16'h7fff : 16'($urandom);
            IN_B = (i == 0) ? 16'h8000 : 16'($urandom);
            e = exp_sample(IN_A, IN_B, s, cfg[3], cfg[2]);
            cvc_host_model_inst.write_byte(`CVC_ADDR_SWAP, {6'h00, s, 1'b0});
            cvc_host_model_inst.write_byte(`CVC_ADDR_CHAN, cfg);
            if (i == 3) cvc_host_model_inst.write_byte(`CVC_ADDR_BATCH, 8'h00);
            check({EA, EB, SW, ZIN}, {cfg[3:2], s, cfg[1:0]});
            wait_pulse(n);
            wait_pulse(n);
            check(16'(n), 16'd20);
            check(CDATA, e);
            check(PUSH, (i != 3));
            check(FDATA, e);
            @(posedge CLOCK);
            #1;
            check(PIN, 1'b1);
            cvc_host_model_inst.write_byte(`CVC_ADDR_SAMPLE_LO, 8'hff);
            cvc_host_model_inst.read_pair(`CVC_ADDR_SAMPLE_LO, lo, hi, ok);
            check({hi, lo}, e);
            check(PIN, 1'b0);
        end
        // Clock enable low freezes the rate counter for seven edges and masks a write
        wait_pulse(n);
        @(posedge CLOCK);
        #1;
        CE = 1'b0;
        cvc_host_model_inst.write_byte(`CVC_ADDR_CHAN, 8'h00);
        repeat (5) @(posedge CLOCK);
        #1;
        CE = 1'b1;
        wait_pulse(n);
        check(16'(n), 16'd19);
        check({EA, EB, ZIN}, {cfg[3:2], cfg[1:0]});
        cvc_host_model_inst.write_byte(`CVC_ADDR_CHAN, 8'h00);
        wait_pulse(n);
        check(16'(n), 16'd60);
        tally_and_finish();
    end
endmodule : testbench

// >>> include/cvc_params.svh
// Register offsets, field positions, reset values and timing of the charge channel
`ifndef CVC_PARAMS_SVH
`define CVC_PARAMS_SVH

`define CVC_ADDR_BATCH        8'h0b
`define CVC_ADDR_ACCEL        8'h10
`define CVC_ADDR_GYRO         8'h11
`define CVC_ADDR_CHAN         8'h16
`define CVC_ADDR_SWAP         8'h19
`define CVC_ADDR_SAMPLE_LO    8'h3a
`define CVC_ADDR_SAMPLE_HI    8'h3b

`define CVC_BIT_CHAN_EN       7
`define CVC_BIT_ROUTE         6
`define CVC_BIT_ELEC_A_EN     3
`define CVC_BIT_ELEC_B_EN     2
`define CVC_FLD_ZIN_HI        1
`define CVC_FLD_ZIN_LO        0
`define CVC_BIT_BATCH         2
`define CVC_BIT_SWAP          1

`define CVC_RESET_BYTE        8'h00
`define CVC_UNMAPPED_BYTE     8'h00

`define CVC_CLOCK_HZ          100000000
`define CVC_RATE_HZ           240
`define CVC_PERIOD_CYCLES     (`CVC_CLOCK_HZ / `CVC_RATE_HZ)

`endif

// >>> include/cvc_pkg.sv
// Shared types of the charge channel controller
package cvc_pkg;
    typedef logic [7:0]         cvc_byte_t;
    typedef logic signed [15:0] cvc_sample_t;
    typedef enum logic [0:0] {CVC_IDLE, CVC_RUN} cvc_rate_state_t;
endpackage : cvc_pkg

// >>> rtl/cvc_ctrl.sv
// Charge-variation channel control, sampling and register readout
//
// How it works
// - The host writes the control registers with single-byte writes and reads all registers through auto-incrementing reads.
// - Writing 0xC0 to 0x16 enables the channel and routes its ready event to the second pin.
// - Each sample sits in 3Ah and 3Bh and is fetched by a two-byte read from 3Ah.
// - While enabled, samples arrive at a fixed 240 Hz independent of any host rate setting.
// - With the batch bit of 0Bh set, each sample is pushed toward the FIFO.
// - A two-bit field of 16h selects the input impedance of the channel buffers.
// - The swap bit of 19h exchanges the two electrode inputs internally.
// - Separate enables in 16h select single-ended or differential use; 0xCC turns all on.
// - The sample is the difference of the two inputs; an unused input contributes nothing.
// - Each sample is also offered to the learning core and the state machine engine.
`timescale 1ns/10ps
`include "cvc_params.svh"
module cvc_ctrl
    import cvc_pkg::*;
#(
    parameter int SAMPLE_PERIOD = `CVC_PERIOD_CYCLES
) (
    input  wire logic        CLOCK,
    input  wire logic        RESETN,
    input  wire logic        CE,
    input  wire logic        WR_EN,
    input  wire logic        RD_EN,
    input  wire logic        RD_FIRST,
    input  wire logic [7:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    output logic      [7:0]  RDATA,
    output logic             RD_VALID,
    input  wire cvc_sample_t ELECTRODE_IN_A,
    input  wire cvc_sample_t ELECTRODE_IN_B,
    output logic      [7:0]  ACCEL_MODE,
    output logic      [7:0]  GYRO_MODE,
    output logic      [1:0]  INPUT_IMPEDANCE_SEL,
    output logic             ELECTRODE_A_ENABLE,
    output logic             ELECTRODE_B_ENABLE,
    output logic             ELECTRODE_SWAP,
    output logic             SECOND_INTERRUPT_PIN,
    output logic             FIFO_PUSH,
    output cvc_sample_t      FIFO_DATA,
    output logic             CORE_SAMPLE_VALID,
    output cvc_sample_t      CORE_SAMPLE
);
    initial begin
        if (SAMPLE_PERIOD < 2) $error("cvc_ctrl: SAMPLE_PERIOD must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register file

    cvc_byte_t reg_batch;
    cvc_byte_t reg_accel;
    cvc_byte_t reg_gyro;
    cvc_byte_t reg_chan;
    cvc_byte_t reg_swap;

    // Single-byte write decode; sample bytes are read-only
    wire wr_batch = CE && WR_EN && (ADDR == `CVC_ADDR_BATCH);
    wire wr_accel = CE && WR_EN && (ADDR == `CVC_ADDR_ACCEL);
    wire wr_gyro  = CE && WR_EN && (ADDR == `CVC_ADDR_GYRO);
    wire wr_chan  = CE && WR_EN && (ADDR == `CVC_ADDR_CHAN);
    wire wr_swap  = CE && WR_EN && (ADDR == `CVC_ADDR_SWAP);

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            reg_batch <= `CVC_RESET_BYTE;
            reg_accel <= `CVC_RESET_BYTE;
            reg_gyro  <= `CVC_RESET_BYTE;
            reg_chan  <= `CVC_RESET_BYTE;
            reg_swap  <= `CVC_RESET_BYTE;
        end else begin
            if (wr_batch) reg_batch <= WDATA;
            if (wr_accel) reg_accel <= WDATA;
            if (wr_gyro)  reg_gyro  <= WDATA;
            if (wr_chan)  reg_chan  <= WDATA;
            if (wr_swap)  reg_swap  <= WDATA;
        end
    end

    // Field extraction
    wire chan_en  = reg_chan[`CVC_BIT_CHAN_EN];
    wire route_en = reg_chan[`CVC_BIT_ROUTE];
    wire elec_a   = reg_chan[`CVC_BIT_ELEC_A_EN];
    wire elec_b   = reg_chan[`CVC_BIT_ELEC_B_EN];
    wire batch_en = reg_batch[`CVC_BIT_BATCH];
    wire swap_en  = reg_swap[`CVC_BIT_SWAP];

    assign ACCEL_MODE          = reg_accel;
    assign GYRO_MODE           = reg_gyro;
    assign INPUT_IMPEDANCE_SEL = reg_chan[`CVC_FLD_ZIN_HI:`CVC_FLD_ZIN_LO];
    assign ELECTRODE_A_ENABLE  = elec_a;
    assign ELECTRODE_B_ENABLE  = elec_b;
    assign ELECTRODE_SWAP      = swap_en;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Sampling

    logic tick;

    cvc_rate_gen #(
        .PERIOD (SAMPLE_PERIOD)
    ) u_rate (
        .clk   (CLOCK),
        .rst_n (RESETN),
        .ce    (CE),
        .run   (chan_en),
        .tick  (tick)
    );

    // Swap, per-input enable and difference with saturation
    wire cvc_sample_t   pos_in  = swap_en ? ELECTRODE_IN_B : ELECTRODE_IN_A;
    wire cvc_sample_t   neg_in  = swap_en ? ELECTRODE_IN_A : ELECTRODE_IN_B;
    wire cvc_sample_t   pos_use = elec_a ? pos_in : '0;
    wire cvc_sample_t   neg_use = elec_b ? neg_in : '0;
    wire signed [16:0]  diff    = {pos_use[15], pos_use} - {neg_use[15], neg_use};
    wire                ovf     = diff[16] != diff[15];
    wire cvc_sample_t   next_sample = ovf ? {diff[16], {15{~diff[16]}}} : diff[15:0];

    cvc_sample_t sample;
    logic        strobe;
    logic        ready_flag;
    logic [7:0]  hi_hold;

    // Read strobe of the low byte clears the ready flag
    wire [7:0] rd_addr;
    wire       rd_lo    = CE && RD_EN && (rd_addr == `CVC_ADDR_SAMPLE_LO);
    wire       rd_hi    = CE && RD_EN && (rd_addr == `CVC_ADDR_SAMPLE_HI);

    // Sample capture at the fixed rate, plus ready flag with set over clear
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            sample     <= '0;
            strobe     <= 1'b0;
            ready_flag <= 1'b0;
        end else if (CE) begin
            strobe <= tick;
            if (tick) sample <= next_sample;
            if (tick) ready_flag <= 1'b1;
            else if (rd_lo || !chan_en) ready_flag <= 1'b0;
        end
    end

    assign SECOND_INTERRUPT_PIN = ready_flag && route_en;
    assign FIFO_PUSH            = strobe && batch_en;
    assign FIFO_DATA            = sample;
    assign CORE_SAMPLE_VALID    = strobe;
    assign CORE_SAMPLE          = sample;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Read port with address auto-increment

    logic [7:0] rd_ptr;
    assign rd_addr = RD_FIRST ? ADDR : rd_ptr;

    // Read multiplexer; the high byte comes from the copy taken with the low byte
    wire [7:0] rd_mux =
        (rd_addr == `CVC_ADDR_BATCH)     ? reg_batch   :
        (rd_addr == `CVC_ADDR_ACCEL)     ? reg_accel   :
        (rd_addr == `CVC_ADDR_GYRO)      ? reg_gyro    :
        (rd_addr == `CVC_ADDR_CHAN)      ? reg_chan    :
        (rd_addr == `CVC_ADDR_SWAP)      ? reg_swap    :
        (rd_addr == `CVC_ADDR_SAMPLE_LO) ? sample[7:0] :
        (rd_addr == `CVC_ADDR_SAMPLE_HI) ? hi_hold     :
                                           `CVC_UNMAPPED_BYTE;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rd_ptr   <= 8'h00;
            RDATA    <= 8'h00;
            RD_VALID <= 1'b0;
            hi_hold  <= 8'h00;
        end else if (CE) begin
            RD_VALID <= RD_EN;
            if (RD_EN) begin
                RDATA  <= rd_mux;
                rd_ptr <= rd_addr + 8'h01;
            end
            if (rd_lo) hi_hold <= sample[15:8];
            else if (!rd_hi) hi_hold <= sample[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks

    a_route_pin_gate: assert property (@(posedge CLOCK) disable iff (!RESETN)
        SECOND_INTERRUPT_PIN |-> (reg_chan[`CVC_BIT_ROUTE] && ready_flag))
        else $error("second interrupt pin high without routing");

    a_ready_after_tick: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (CE && tick) |=> ready_flag)
        else $error("ready flag not set by a new sample");

    a_batch_push_gate: assert property (@(posedge CLOCK) disable iff (!RESETN)
        FIFO_PUSH |-> (reg_batch[`CVC_BIT_BATCH] && CORE_SAMPLE_VALID))
        else $error("fifo push without batch bit");

    a_tick_spacing: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (tick && CE) |=> !tick)
        else $error("sample ticks too close");

    a_no_tick_off: assert property (@(posedge CLOCK) disable iff (!RESETN)
        !chan_en |-> !tick)
        else $error("sample while channel disabled");

    a_sample_load: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (CE && tick) |=> (sample == $past(next_sample)) && strobe)
        else $error("sample not loaded on tick");

    a_swap_route: assert property (@(posedge CLOCK) disable iff (!RESETN)
        reg_swap[`CVC_BIT_SWAP] |-> (pos_in == ELECTRODE_IN_B && neg_in == ELECTRODE_IN_A))
        else $error("electrode swap not applied");

    a_unused_input: assert property (@(posedge CLOCK) disable iff (!RESETN)
        !reg_chan[`CVC_BIT_ELEC_B_EN] |-> (neg_use == 16'sh0000))
        else $error("disabled electrode contributes");

    a_read_increment: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (CE && RD_EN && RD_FIRST && ADDR == `CVC_ADDR_SAMPLE_LO)
        |=> (rd_ptr == `CVC_ADDR_SAMPLE_HI) && RD_VALID)
        else $error("read pointer did not advance");

    a_impedance_field: assert property (@(posedge CLOCK) disable iff (!RESETN)
        wr_chan |=> (INPUT_IMPEDANCE_SEL == $past(WDATA[1:0])))
        else $error("impedance field not taken from write");
endmodule : cvc_ctrl

// >>> rtl/cvc_rate_gen.sv
// Fixed output-rate tick generator for the charge channel
`timescale 1ns/10ps
`include "cvc_params.svh"
module cvc_rate_gen
    import cvc_pkg::*;
#(
    parameter int PERIOD = `CVC_PERIOD_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic run,
    output logic      tick
);
    initial begin
        if (PERIOD < 2) $error("cvc_rate_gen: PERIOD must be at least 2");
    end

    localparam int CW = $clog2(PERIOD);

    cvc_rate_state_t state;
    logic [CW-1:0]   count;
    wire             at_end = (count == CW'(PERIOD - 1));

    // Free counter restarted whenever the channel is switched on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= CVC_IDLE;
            count <= '0;
        end else if (ce) begin
            case (state)
                CVC_IDLE: begin
                    count <= '0;
                    if (run) state <= CVC_RUN;
                end
                CVC_RUN: begin
                    count <= at_end ? '0 : count + 1'b1;
                    if (!run) state <= CVC_IDLE;
                end
                default: state <= CVC_IDLE;
            endcase
        end
    end

    assign tick = ce && run && (state == CVC_RUN) && at_end;
endmodule : cvc_rate_gen
